/* File: fault_supervisor_defines.vh */
/*
 * constants for the fault and watchdog supervisor: register offsets, field
 * positions, reset values and timing counts. assumes a 50 MHz core clock.
 */
`ifndef FAULT_SUPERVISOR_DEFINES_VH
`define FAULT_SUPERVISOR_DEFINES_VH

`define CLK_FREQ_HZ 50000000
// register offsets on the plain port (word index)
`define ADDR_WDOG 5'h00
`define ADDR_CTRL 5'h01
`define ADDR_STAT0 5'h05
`define ADDR_STAT1 5'h06
`define ADDR_STAT2 5'h07
// watchdog register fields
`define WD_ARM_BIT 7
`define WD_PER_HI 6
`define WD_PER_LO 3
`define WD_OPEN_HI 2
`define WD_OPEN_LO 1
`define WDOG_RESET 8'h04
// control register fields
`define CTRL_MOTOR_ENABLE_BIT 0
`define CTRL_SLEEP_BIT 1
`define CTRL_PUSHPULL_BIT 2
`define CTRL_RESET 8'h00
// status 0: bit0 warn, bit1 tsd, bit2 fired
`define S0_WARN_BIT 0
`define S0_TSD_BIT 1
`define S0_WDF_BIT 2
// status 1/2: bits3:0 over-current per transistor, bit4 open coil, bit5 pump (s1)
`define S_OPEN_BIT 4
`define S1_PUMP_BIT 5
// times
`define PUMP_WIN_US 250
`define PUMP_WIN_CYC (`PUMP_WIN_US * (`CLK_FREQ_HZ / 1000000))
`define HOLD_MS 100
`define HOLD_CYC (`HOLD_MS * (`CLK_FREQ_HZ / 1000))
`define WD_STEP_MS 32
`define WD_STEP_CYC (`WD_STEP_MS * (`CLK_FREQ_HZ / 1000))
`define OPEN_STEP_US 200
`define OPEN_STEP_CYC (`OPEN_STEP_US * (`CLK_FREQ_HZ / 1000000))
`define CNT_W 32

`endif

/* File: fault_and_watchdog_supervisor.v */
/*
 * fault latching, error pin, motor-enable gating and host watchdog.
 * fault_latch holds one group of set-wins fault flags; full_duty_timer
 * times one coil's saturated regulator for open-coil detection. both
 * live here beside the top so the block stays a single file.
 * assumes analog indications arrive synchronous to i_core_clk and that the
 * serial front end turns host accesses into single-cycle strobes.
 */
// Function
// - thermal warning drives error pin, not drivers
// - thermal shutdown puts drivers high impedance
// - leave shutdown: warning gone, flag cleared
// - over-current raises error, clears motor enable
// - one over-current flag per driver transistor
// - over-current latched until status read
// - full duty too long latches open coil
// - two-bit field selects open-coil interval
// - pump failure latches flag, disables motor
// - reading status 1 clears pump flag
// - 250 us unlatched pump window after reset
// - watchdog pin held low 100 ms
// - arm bit starts up-counting watchdog
// - expiry pulses reset even if re-armed in that cycle; sets fired flag only if not re-armed
// - fired flag zero cold, one warm
// - pins open-drain until push-pull selected
// - error pin reports all but undervoltage; most disable motor
// - motor enable only with no latched error
// - undervoltage disables until supply recovers
// - sleep blocks clear-on-read
// - status snapshot refreshed only while deselected
`timescale 1ns/100ps
`include "fault_supervisor_defines.vh"

module fault_and_watchdog_supervisor (
    input wire i_core_clk,
    input wire i_rstn,
    input wire [4:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire i_chip_select_n,
    input wire i_thermal_warn,
    input wire i_thermal_sd,
    input wire [3:0] i_oc_x,
    input wire [3:0] i_oc_y,
    input wire i_full_duty_x,
    input wire i_full_duty_y,
    input wire i_pump_low,
    input wire i_undervolt,
    output wire o_motor_enable,
    output wire o_drivers_hiz,
    output wire o_sleep,
    output wire o_error_out_n,
    output wire o_error_oe_n,
    output wire o_watchdog_out_n,
    output wire o_watchdog_oe_n
);
    reg [7:0] wdog_reg;
    reg [7:0] ctrl_reg;
    wire [3:0] oc_x_reg;
    wire [3:0] oc_y_reg;
    wire open_x_reg;
    wire open_y_reg;
    wire pump_reg;
    wire tsd_reg;
    reg fired_reg;
    reg uv_block_reg;
    reg [7:0] snap0_reg;
    reg [7:0] snap1_reg;
    reg [7:0] snap2_reg;
    reg [`CNT_W-1:0] pump_cnt_reg;
    reg pump_win_reg;
    reg [`CNT_W-1:0] hold_cnt_reg;
    reg hold_reg;
    reg [`CNT_W-1:0] wd_cnt_reg;
    reg wd_run_reg;

    wire rd_s0 = i_rd && (i_addr == `ADDR_STAT0);
    wire rd_s1 = i_rd && (i_addr == `ADDR_STAT1);
    wire rd_s2 = i_rd && (i_addr == `ADDR_STAT2);
    wire sleeping = ctrl_reg[`CTRL_SLEEP_BIT];
    wire clr_ok = !sleeping;
    wire arm_wr = i_wr && (i_addr == `ADDR_WDOG) && i_wdata[`WD_ARM_BIT];

    // open-coil interval: 1..4 steps chosen by the two-bit field
    wire [`CNT_W-1:0] open_lim = (({30'h0, wdog_reg[`WD_OPEN_HI:`WD_OPEN_LO]}) + 32'h1) * `OPEN_STEP_CYC;
    // watchdog period: (sel+1) * 32 ms
    wire [`CNT_W-1:0] wd_lim = (({28'h0, wdog_reg[`WD_PER_HI:`WD_PER_LO]}) + 32'h1) * `WD_STEP_CYC;

    wire ox_hit;
    wire oy_hit;
    wire pump_latch = i_pump_low && !pump_win_reg;
    wire wd_expire = wd_run_reg && (wd_cnt_reg >= wd_lim - 32'h1);

    // any latched fault, all of which block the motor
    wire latched = (|oc_x_reg) || (|oc_y_reg) || open_x_reg || open_y_reg || pump_reg || tsd_reg;
    wire new_fault = (|i_oc_x) || (|i_oc_y) || ox_hit || oy_hit || pump_latch || i_thermal_sd;

    // power-on charge-pump window: pump error shown but not latched
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pump_cnt_reg <= 32'h0;
            pump_win_reg <= 1'b1;
        end else if (pump_win_reg) begin
            pump_cnt_reg <= pump_cnt_reg + 32'h1;
            if (pump_cnt_reg >= `PUMP_WIN_CYC - 1) begin
                pump_win_reg <= 1'b0;
            end
        end
    end

    // open-coil full-duty timers, one per coil, restart whenever duty drops
    full_duty_timer #(
        .CW(`CNT_W)
    ) u_full_duty_timer_x (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_full_duty(i_full_duty_x),
        .i_limit(open_lim),
        .o_hit(ox_hit)
    );
    full_duty_timer #(
        .CW(`CNT_W)
    ) u_full_duty_timer_y (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_full_duty(i_full_duty_y),
        .i_limit(open_lim),
        .o_hit(oy_hit)
    );

    // clear-on-read strobes; shutdown stays latched while still above warning level
    wire clr_s0 = rd_s0 && clr_ok && !i_thermal_warn;
    wire clr_s1 = rd_s1 && clr_ok;
    wire clr_s2 = rd_s2 && clr_ok;

    // x bridge over-current, one flag per transistor, cleared by status 1
    fault_latch #(
        .WIDTH(4)
    ) u_fault_latch_oc_x (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_set(i_oc_x),
        .i_clear(clr_s1),
        .o_flags(oc_x_reg)
    );

    // y bridge over-current, one flag per transistor, cleared by status 2
    fault_latch #(
        .WIDTH(4)
    ) u_fault_latch_oc_y (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_set(i_oc_y),
        .i_clear(clr_s2),
        .o_flags(oc_y_reg)
    );

    // open x coil, shares status 1 with the x over-current flags
    fault_latch #(
        .WIDTH(1)
    ) u_fault_latch_open_x (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_set(ox_hit),
        .i_clear(clr_s1),
        .o_flags(open_x_reg)
    );

    // open y coil, shares status 2 with the y over-current flags
    fault_latch #(
        .WIDTH(1)
    ) u_fault_latch_open_y (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_set(oy_hit),
        .i_clear(clr_s2),
        .o_flags(open_y_reg)
    );

    // charge-pump failure, only once the start-up window has closed
    fault_latch #(
        .WIDTH(1)
    ) u_fault_latch_pump (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_set(pump_latch),
        .i_clear(clr_s1),
        .o_flags(pump_reg)
    );

    // thermal shutdown, cleared by status 0 only when the warning is gone
    fault_latch #(
        .WIDTH(1)
    ) u_fault_latch_tsd (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_set(i_thermal_sd),
        .i_clear(clr_s0),
        .o_flags(tsd_reg)
    );

    // undervoltage blocks enabling until the indication clears (hysteresis is analog)
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            uv_block_reg <= 1'b0;
        end else begin
            uv_block_reg <= i_undervolt;
        end
    end

    // enable is refused on any latched or arriving fault and on low supply
    wire motor_enable_ok = !latched && !new_fault && !i_undervolt && !uv_block_reg;

    // register writes; motor enable is refused while anything is latched
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wdog_reg <= `WDOG_RESET;
            ctrl_reg <= `CTRL_RESET;
        end else begin
            if (i_wr && i_addr == `ADDR_WDOG) begin
                wdog_reg <= i_wdata;
            end
            if (i_wr && i_addr == `ADDR_CTRL) begin
                ctrl_reg[7:1] <= i_wdata[7:1];
                ctrl_reg[`CTRL_MOTOR_ENABLE_BIT] <= i_wdata[`CTRL_MOTOR_ENABLE_BIT] && motor_enable_ok;
            end else if (new_fault || i_undervolt) begin
                ctrl_reg[`CTRL_MOTOR_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // watchdog timer; re-arm write restarts the count (host duty to do so in time)
    // the period field is read live, so a new period applies to the running count
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wd_cnt_reg <= 32'h0;
            wd_run_reg <= 1'b0;
            fired_reg <= 1'b0;
        end else begin
            if (arm_wr) begin
                wd_cnt_reg <= 32'h0;
                wd_run_reg <= 1'b1;
            end else if (wd_expire) begin
                wd_cnt_reg <= 32'h0;
                wd_run_reg <= 1'b0;
                fired_reg <= 1'b1;
            end else if (wd_run_reg) begin
                wd_cnt_reg <= wd_cnt_reg + 32'h1;
            end
        end
    end

    // reset-pulse hold: after power-on and after each expiry
    // an expiry during a hold restarts the full pulse length
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hold_cnt_reg <= 32'h0;
            hold_reg <= 1'b1;
        end else if (wd_expire) begin
            hold_cnt_reg <= 32'h0;
            hold_reg <= 1'b1;
        end else if (hold_reg) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
            if (hold_cnt_reg >= `HOLD_CYC - 1) begin
                hold_reg <= 1'b0;
            end
        end
    end

    // live status words as a deselected host would next capture them
    wire [7:0] stat0_live = {5'h0, fired_reg, tsd_reg, i_thermal_warn};
    wire [7:0] stat1_live = {2'h0, pump_reg, open_x_reg, oc_x_reg};
    wire [7:0] stat2_live = {3'h0, open_y_reg, oc_y_reg};

    // status snapshots only follow the latches while the host is deselected
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            snap0_reg <= 8'h00;
            snap1_reg <= 8'h00;
            snap2_reg <= 8'h00;
        end else if (i_chip_select_n) begin
            snap0_reg <= stat0_live;
            snap1_reg <= stat1_live;
            snap2_reg <= stat2_live;
        end
    end

    // read data one cycle after the strobe, zero otherwise and for unmapped
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `ADDR_WDOG: o_rdata <= wdog_reg;
                `ADDR_CTRL: o_rdata <= ctrl_reg;
                `ADDR_STAT0: o_rdata <= snap0_reg;
                `ADDR_STAT1: o_rdata <= snap1_reg;
                `ADDR_STAT2: o_rdata <= snap2_reg;
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // error pin: latched faults, live warning and the unlatched pump window
    wire err_act = latched || i_thermal_warn || (pump_win_reg && i_pump_low);
    wire push = ctrl_reg[`CTRL_PUSHPULL_BIT];

    assign o_motor_enable = ctrl_reg[`CTRL_MOTOR_ENABLE_BIT];
    // warning alone does not float the bridge; shutdown or sleep does
    assign o_drivers_hiz = tsd_reg || sleeping || !ctrl_reg[`CTRL_MOTOR_ENABLE_BIT];
    assign o_sleep = sleeping;
    // open drain drives only low; push-pull drives both levels
    assign o_error_out_n = !err_act;
    assign o_error_oe_n = !(err_act || push);
    assign o_watchdog_out_n = !hold_reg;
    assign o_watchdog_oe_n = !(hold_reg || push);
endmodule

// one group of fault flags; an event in the cycle of its clearing read wins,
// so a fault that strikes during the read is never lost
module fault_latch #(
    parameter WIDTH = 1
) (
    input wire i_core_clk,
    input wire i_rstn,
    input wire [WIDTH-1:0] i_set,
    input wire i_clear,
    output reg [WIDTH-1:0] o_flags
);
    // set beats clear
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_flags <= {WIDTH{1'b0}};
        end else if (i_clear) begin
            o_flags <= i_set;
        end else begin
            o_flags <= o_flags | i_set;
        end
    end
endmodule

// full-duty interval timer for one coil; the count parks at the limit so it
// cannot wrap and miss a regulator that stays saturated
module full_duty_timer #(
    parameter CW = `CNT_W
) (
    input wire i_core_clk,
    input wire i_rstn,
    input wire i_full_duty,
    input wire [CW-1:0] i_limit,
    output wire o_hit
);
    localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
    reg [CW-1:0] cnt_reg;

    // hit once the duty has stood for the whole programmed interval
    assign o_hit = i_full_duty && (cnt_reg >= i_limit - CNT_ONE);

    // restart whenever the duty drops, hold once the limit is met
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= {CW{1'b0}};
        end else if (!i_full_duty) begin
            cnt_reg <= {CW{1'b0}};
        end else if (!o_hit) begin
            cnt_reg <= cnt_reg + CNT_ONE;
        end
    end
endmodule

/* File: host_pin_model.sv */
/* board side of the two supervisor pins as the host sees them.
   assumes both pins carry external pull-ups. */
`timescale 1ns/100ps
module host_pin_model (
    input wire i_error_out_n,
    input wire i_error_oe_n,
    input wire i_watchdog_out_n,
    input wire i_watchdog_oe_n,
    output wire o_error_pin,
    output wire o_watchdog_pin
);
    // a released open-drain pin floats up to the pull-up, never to the last level
    assign o_error_pin = i_error_oe_n ? 1'b1 : i_error_out_n;
    assign o_watchdog_pin = i_watchdog_oe_n ? 1'b1 : i_watchdog_out_n;
endmodule

/* File: fault_supervisor_checker.sv */
/* concurrent checks on the supervisor top ports.
   assumes a bind to the design top, one clock domain. */
`timescale 1ns/100ps
module fault_supervisor_checker (
    input wire i_core_clk,
    input wire i_rstn,
    input wire [4:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_thermal_warn,
    input wire i_thermal_sd,
    input wire [3:0] i_oc_x,
    input wire [3:0] i_oc_y,
    input wire i_pump_low,
    input wire i_undervolt,
    input wire o_motor_enable,
    input wire o_drivers_hiz,
    input wire o_error_out_n,
    input wire o_watchdog_out_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    // faults get two cycles of slack for the latch stage
    chk_warn_err_pin: assert property (i_thermal_warn |-> !o_error_out_n)
        else $error("warning without error pin");
    chk_tsd_hiz: assert property (i_thermal_sd |-> ##[0:2] o_drivers_hiz)
        else $error("shutdown without high impedance");
    chk_oc_motor_off: assert property ((|i_oc_x) |-> ##[1:2] !o_motor_enable)
        else $error("over-current left motor on");
    chk_oc_err_pin: assert property ((|i_oc_y) |-> ##[0:2] !o_error_out_n)
        else $error("over-current without error pin");
    chk_pump_err_pin: assert property (i_pump_low |-> ##[0:2] !o_error_out_n)
        else $error("pump low without error pin");
    chk_uv_motor_off: assert property (i_undervolt |-> ##[1:2] !o_motor_enable)
        else $error("undervoltage left motor on");
    // the enable may only rise from a control write carrying bit 0
    chk_enable_cause: assert property ($rose(o_motor_enable) |-> $past(i_wr) && $past(i_addr) == 5'h01
        && ($past(i_wdata) & 8'h01) == 8'h01)
        else $error("motor enable rose without a write");
    chk_wd_hold: assert property ($rose(i_rstn) |-> !o_watchdog_out_n [*8])
        else $error("watchdog pin released early");
endmodule
bind fault_and_watchdog_supervisor fault_supervisor_checker u_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_thermal_warn(i_thermal_warn), .i_thermal_sd(i_thermal_sd),
    .i_oc_x(i_oc_x), .i_oc_y(i_oc_y), .i_pump_low(i_pump_low), .i_undervolt(i_undervolt),
    .o_motor_enable(o_motor_enable), .o_drivers_hiz(o_drivers_hiz), .o_error_out_n(o_error_out_n),
    .o_watchdog_out_n(o_watchdog_out_n));

/* File: fault_and_watchdog_supervisor_tb_top.sv */
/* directed bench for the supervisor over its register port.
   assumes the defines header and the pin model are compiled first. */
`timescale 1ns/100ps
`include "fault_supervisor_defines.vh"
`define PE @(posedge i_core_clk)
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module fault_and_watchdog_supervisor_tb_top;
    logic i_core_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_chip_select_n = 1;
    logic [4:0] i_addr = 0;
    logic [7:0] i_wdata = 0;
    logic i_thermal_warn = 0, i_thermal_sd = 0, i_full_duty_x = 0, i_full_duty_y = 0, i_pump_low = 0, i_undervolt = 0;
    logic [3:0] i_oc_x = 0, i_oc_y = 0;
    wire [7:0] o_rdata;
    wire o_motor_enable, o_drivers_hiz, o_sleep, o_error_out_n, o_error_oe_n, o_watchdog_out_n, o_watchdog_oe_n;
    wire err_pin, wd_pin;
    int num_errors = 0, n_checks = 0;
    always #10 i_core_clk = ~i_core_clk;
    fault_and_watchdog_supervisor u_fault_and_watchdog_supervisor (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_chip_select_n(i_chip_select_n), .i_thermal_warn(i_thermal_warn), .i_thermal_sd(i_thermal_sd),
        .i_oc_x(i_oc_x), .i_oc_y(i_oc_y), .i_full_duty_x(i_full_duty_x), .i_full_duty_y(i_full_duty_y),
        .i_pump_low(i_pump_low), .i_undervolt(i_undervolt), .o_motor_enable(o_motor_enable),
        .o_drivers_hiz(o_drivers_hiz), .o_sleep(o_sleep), .o_error_out_n(o_error_out_n),
        .o_error_oe_n(o_error_oe_n), .o_watchdog_out_n(o_watchdog_out_n), .o_watchdog_oe_n(o_watchdog_oe_n));
    host_pin_model u_host_pin_model (.i_error_out_n(o_error_out_n), .i_error_oe_n(o_error_oe_n),
        .i_watchdog_out_n(o_watchdog_out_n), .i_watchdog_oe_n(o_watchdog_oe_n),
        .o_error_pin(err_pin), .o_watchdog_pin(wd_pin));
    // one-cycle strobes launched just after an edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        `PE;
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        `PE i_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        `PE;
        i_rd <= 1'b1;
        i_addr <= a;
        `PE i_rd <= 1'b0;
        #1;
        `CHK("read data", e, o_rdata)
    endtask
    task automatic tick(input int n);
        repeat (n) `PE;
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard well beyond the longest scenario
    initial begin
        #1500000;
        num_errors++;
        close_out;
    end
    initial begin
        repeat (16) `PE;
        i_rstn <= 1'b1;
        // a pump dip inside the start-up window shows but must not latch
        `PE i_pump_low <= 1'b1;
        tick(2);
        `CHK("error pin", 1'b0, err_pin)
        `PE i_pump_low <= 1'b0;
        tick(3);
        `CHK("error pin", 1'b1, err_pin)
        `CHK("reset pin", 1'b0, wd_pin)
        // the start-up delay before transfers is cut short to keep the run brief
        rd(`ADDR_STAT1, 8'h00);
        rd(`ADDR_WDOG, `WDOG_RESET);
        rd(`ADDR_CTRL, `CTRL_RESET);
        wr(`ADDR_STAT0, 8'hFF);
        rd(`ADDR_STAT0, 8'h00);
        rd(5'h1F, 8'h00);
        // over-current kills the motor until the flag is read out
        wr(`ADDR_CTRL, 8'h01);
        `PE i_oc_x <= 4'h2;
        `PE i_oc_x <= 4'h0;
        tick(2);
        `CHK("error pin", 1'b0, err_pin)
        wr(`ADDR_CTRL, 8'h01);
        rd(`ADDR_CTRL, 8'h00);
        rd(`ADDR_STAT1, 8'h02);
        `CHK("error pin", 1'b1, err_pin)
        wr(`ADDR_CTRL, 8'h01);
        rd(`ADDR_CTRL, 8'h01);
        `PE i_oc_y <= 4'h8;
        `PE i_oc_y <= 4'h0;
        rd(`ADDR_STAT2, 8'h08);
        rd(`ADDR_STAT2, 8'h00);
        // undervoltage refuses enable until the supply recovers
        wr(`ADDR_CTRL, 8'h01);
        `PE i_undervolt <= 1'b1;
        wr(`ADDR_CTRL, 8'h01);
        rd(`ADDR_CTRL, 8'h00);
        `PE i_undervolt <= 1'b0;
        wr(`ADDR_CTRL, 8'h01);
        rd(`ADDR_CTRL, 8'h01);
        // warning alone keeps the motor; shutdown sticks while warm
        `PE i_thermal_warn <= 1'b1;
        tick(2);
        `CHK("motor", 1'b1, o_motor_enable)
        `CHK("hiz", 1'b0, o_drivers_hiz)
        `PE i_thermal_sd <= 1'b1;
        `PE i_thermal_sd <= 1'b0;
        tick(2);
        `CHK("motor", 1'b0, o_motor_enable)
        `CHK("hiz", 1'b1, o_drivers_hiz)
        rd(`ADDR_STAT0, 8'h03);
        rd(`ADDR_STAT0, 8'h03);
        `PE i_thermal_warn <= 1'b0;
        tick(2);
        rd(`ADDR_STAT0, 8'h02);
        rd(`ADDR_STAT0, 8'h00);
        // reads in sleep leave the latches alone
        wr(`ADDR_CTRL, 8'h02);
        #1;
        `CHK("sleep", 1'b1, o_sleep)
        `PE i_oc_x <= 4'h1;
        `PE i_oc_x <= 4'h0;
        rd(`ADDR_STAT1, 8'h01);
        rd(`ADDR_STAT1, 8'h01);
        wr(`ADDR_CTRL, 8'h00);
        rd(`ADDR_STAT1, 8'h01);
        rd(`ADDR_STAT1, 8'h00);
        // snapshot frozen while selected
        `PE i_chip_select_n <= 1'b0;
        `PE i_thermal_warn <= 1'b1;
        rd(`ADDR_STAT0, 8'h00);
        `PE i_chip_select_n <= 1'b1;
        rd(`ADDR_STAT0, 8'h01);
        `PE i_thermal_warn <= 1'b0;
        tick(2);
        `CHK("error drive", 1'b1, o_error_oe_n)
        wr(`ADDR_CTRL, 8'h04);
        tick(1);
        `CHK("error drive", 1'b0, o_error_oe_n)
        // past the start-up window a pump dip latches
        tick(12600);
        `PE i_pump_low <= 1'b1;
        `PE i_pump_low <= 1'b0;
        tick(3);
        `CHK("error pin", 1'b0, err_pin)
        rd(`ADDR_STAT1, 8'h20);
        rd(`ADDR_STAT1, 8'h00);
        // open-coil interval select 1 is 400 us of full duty
        wr(`ADDR_WDOG, 8'h02);
        wr(`ADDR_CTRL, 8'h01);
        `PE i_full_duty_y <= 1'b1;
        i_full_duty_x <= 1'b1;
        tick(15000);
        `CHK("error pin", 1'b1, err_pin)
        tick(5200);
        `CHK("error pin", 1'b0, err_pin)
        `PE i_full_duty_y <= 1'b0;
        i_full_duty_x <= 1'b0;
        rd(`ADDR_STAT2, 8'h10);
        rd(`ADDR_STAT1, 8'h10);
        // arm, then re-arm well inside the 64 ms period and spaced apart
        wr(`ADDR_WDOG, 8'h88);
        tick(100);
        wr(`ADDR_WDOG, 8'h88);
        rd(`ADDR_WDOG, 8'h88);
        rd(`ADDR_STAT0, 8'h00);
        `CHK("reset pin", 1'b0, wd_pin)
        close_out;
    end
endmodule
